// File: rtl/sensor_spi_command_fsm.v
// Host side command sequencer driving the force sensor over SPI mode 3.
`timescale 1ns/10ps
// Behaviour
// - Result only read while active (host refuses it only while idle and still sends it in shutdown)
// - No idle or coefficient read while active
// - No register write while idle
// - Serial clock idles high, mode three
// - Select toggles only while clock high
// - Data changes on fall, sampled on rise
// - Command byte, acknowledge byte, then payload
// - Address, busy zeros, marker, one data byte
// - After write data, poll until marker
// - Detect marker, never expect busy zeros
// - Clock at most 5 or 1 MHz
// - Register write uses code E0 hex
// - Coefficient read uses code D6 hex
module sensor_spi_command_fsm
#(
  parameter [7:0] CMD_RESET    = 8'h01,
  parameter [7:0] CMD_SHUTDOWN = 8'h02,
  parameter [7:0] CMD_ACTIVE   = 8'h03,
  parameter [7:0] CMD_IDLE     = 8'h04,
  parameter [7:0] CMD_RESULT   = 8'h05
)
(
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       slow_io,
  input  wire       req_valid,
  input  wire [2:0] req_op,
  input  wire [7:0] req_addr,
  input  wire [7:0] req_data,
  input  wire [7:0] req_len,
  output reg        req_ready,
  output reg        done,
  output reg  [1:0] done_status,
  output reg  [1:0] dev_state,
  output reg        sclk,
  output reg        mosi,
  output reg        chip_select_n,
  input  wire       miso,
  output wire       rx_valid,
  output wire [7:0] rx_data,
  input  wire       rx_ready
);
`include "sensor_host_map.vh"

  // --------------------------------------------------------------------
  // States and byte stages
  // --------------------------------------------------------------------
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_LEAD  = 7'h02;
  localparam [6:0] S_SHIFT = 7'h04;
  localparam [6:0] S_NEXT  = 7'h08;
  localparam [6:0] S_HOLD  = 7'h10;
  localparam [6:0] S_LAG   = 7'h20;
  localparam [6:0] S_GAP   = 7'h40;

  localparam [2:0] STG_CMD  = 3'h0;
  localparam [2:0] STG_ACK  = 3'h1;
  localparam [2:0] STG_ADDR = 3'h2;
  localparam [2:0] STG_DATA = 3'h3;
  localparam [2:0] STG_POLL = 3'h4;
  localparam [2:0] STG_COEF = 3'h5;
  localparam [2:0] STG_READ = 3'h6;

  localparam integer POLL_CNT  = `POLL_LIMIT;
  localparam integer GAP_CNT   = `GAP_TICKS;
  localparam [7:0]   POLL_LAST = POLL_CNT[7:0] - 8'h01;
  localparam [1:0]   GAP_LAST  = GAP_CNT[1:0] - 2'h1;

  reg  [6:0] state_ff;
  reg  [2:0] stage_ff;
  reg  [2:0] op_ff;
  reg  [7:0] addr_ff;
  reg  [7:0] data_ff;
  reg  [7:0] len_ff;
  reg  [7:0] tx_ff;
  reg  [7:0] rx_ff;
  reg  [2:0] bit_ff;
  reg        phase_ff;
  reg  [7:0] poll_ff;
  reg  [1:0] gap_ff;
  reg  [1:0] sts_ff;
  reg        miso_meta_ff;
  reg        miso_ff;
  reg        forbid;
  reg  [7:0] cmd_code;
  wire       tick;
  wire       push_w;
  wire       fifo_in_ready;

  // --------------------------------------------------------------------
  // Clock divider and receive buffer
  // --------------------------------------------------------------------
  sclk_tick_gen u_tick
  (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .slow_sel (slow_io),
    .tick     (tick)
  );

  // Read bytes are pushed in the cycle after their last rising edge.
  assign push_w = (state_ff == S_NEXT) && (stage_ff == STG_READ || stage_ff == STG_COEF);

  rx_byte_fifo
  #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (2)
  )
  u_fifo
  (
    .ref_clk   (ref_clk),
    .sys_rst   (sys_rst),
    .in_valid  (push_w),
    .in_data   (rx_ff),
    .in_ready  (fifo_in_ready),
    .out_valid (rx_valid),
    .out_data  (rx_data),
    .out_ready (rx_ready)
  );

  // --------------------------------------------------------------------
  // Command code lookup and host side guard
  // --------------------------------------------------------------------
  always @*
  begin
    case (req_op)
      `OP_RESET:     cmd_code = CMD_RESET;
      `OP_SHUTDOWN:  cmd_code = CMD_SHUTDOWN;
      `OP_ACTIVE:    cmd_code = CMD_ACTIVE;
      `OP_IDLE:      cmd_code = CMD_IDLE;
      `OP_RESULT:    cmd_code = CMD_RESULT;
      `OP_WRITE_REG: cmd_code = `CMD_WRITE_REG;
      default:       cmd_code = `CMD_COEF_READ;
    endcase
    forbid = 1'b0;
    if (dev_state == `DEV_ACTIVE && (req_op == `OP_IDLE || req_op == `OP_COEF_READ))
      forbid = 1'b1;
    if (dev_state == `DEV_IDLE && (req_op == `OP_RESULT || req_op == `OP_WRITE_REG))
      forbid = 1'b1;
    if (req_op > `OP_COEF_READ)
      forbid = 1'b1;
  end

  // --------------------------------------------------------------------
  // Data input synchroniser
  // --------------------------------------------------------------------
  // The output floats while deselected; it is still synchronised every cycle, but bits are only shifted in while selected.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      miso_meta_ff <= 1'b0;
      miso_ff      <= 1'b0;
    end
    else
    begin
      miso_meta_ff <= miso;
      miso_ff      <= miso_meta_ff;
    end
  end

  // --------------------------------------------------------------------
  // Frame sequencer
  // --------------------------------------------------------------------
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff      <= S_IDLE;
      stage_ff      <= STG_CMD;
      op_ff         <= `OP_RESET;
      addr_ff       <= 8'h00;
      data_ff       <= 8'h00;
      len_ff        <= 8'h00;
      tx_ff         <= 8'h00;
      rx_ff         <= 8'h00;
      bit_ff        <= 3'h7;
      phase_ff      <= 1'b0;
      poll_ff       <= 8'h00;
      gap_ff        <= 2'h0;
      sts_ff        <= `STS_OK;
      req_ready     <= 1'b0;
      done          <= 1'b0;
      done_status   <= `STS_OK;
      dev_state     <= `DEV_SHUTDOWN;
      sclk          <= 1'b1;
      mosi          <= 1'b1;
      chip_select_n <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      case (state_ff)
        S_IDLE:
        begin
          if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            op_ff     <= req_op;
            addr_ff   <= req_addr;
            data_ff   <= req_data;
            len_ff    <= req_len;
            if (forbid)
            begin
              done        <= 1'b1;
              done_status <= `STS_REFUSED;
            end
            else
            begin
              chip_select_n <= 1'b0;
              tx_ff         <= cmd_code;
              stage_ff      <= STG_CMD;
              state_ff      <= S_LEAD;
            end
          end
          else
            req_ready <= 1'b1;
        end
        S_LEAD:
        begin
          if (tick)
          begin
            bit_ff   <= 3'h7;
            phase_ff <= 1'b0;
            state_ff <= S_SHIFT;
          end
        end
        S_SHIFT:
        begin
          if (tick)
          begin
            if (!phase_ff)
            begin
              sclk     <= 1'b0;
              mosi     <= tx_ff[7];
              tx_ff    <= {tx_ff[6:0], 1'b0};
              phase_ff <= 1'b1;
            end
            else
            begin
              sclk     <= 1'b1;
              rx_ff    <= {rx_ff[6:0], miso_ff};
              phase_ff <= 1'b0;
              if (bit_ff == 3'h0)
                state_ff <= S_NEXT;
              else
                bit_ff <= bit_ff - 3'h1;
            end
          end
        end
        S_NEXT:
        begin
          tx_ff    <= 8'h00;
          state_ff <= S_LEAD;
          case (stage_ff)
            STG_CMD:
              stage_ff <= STG_ACK;
            STG_ACK:
            begin
              if (rx_ff != `ACK_BYTE)
              begin
                sts_ff   <= `STS_NEGATIVE_ACKNOWLEDGE;
                state_ff <= S_LAG;
              end
              else
              begin
                sts_ff <= `STS_OK;
                case (op_ff)
                  `OP_RESET, `OP_SHUTDOWN:
                  begin
                    dev_state <= `DEV_SHUTDOWN;
                    state_ff  <= S_LAG;
                  end
                  `OP_ACTIVE:
                  begin
                    dev_state <= `DEV_ACTIVE;
                    state_ff  <= S_LAG;
                  end
                  `OP_IDLE:
                  begin
                    dev_state <= `DEV_IDLE;
                    state_ff  <= S_LAG;
                  end
                  `OP_RESULT:
                  begin
                    stage_ff <= STG_READ;
                    state_ff <= (len_ff == 8'h00) ? S_LAG : S_HOLD;
                  end
                  default:
                  begin
                    stage_ff <= STG_ADDR;
                    tx_ff    <= addr_ff;
                  end
                endcase
              end
            end
            STG_ADDR:
            begin
              poll_ff <= 8'h00;
              if (op_ff == `OP_WRITE_REG)
              begin
                stage_ff <= STG_DATA;
                tx_ff    <= data_ff;
              end
              else
                stage_ff <= STG_POLL;
            end
            STG_DATA:
              stage_ff <= STG_POLL;
            STG_POLL:
            begin
              if (rx_ff == `READY_MARK)
              begin
                if (op_ff == `OP_WRITE_REG)
                  state_ff <= S_LAG;
                else
                begin
                  stage_ff <= STG_COEF;
                  state_ff <= S_HOLD;
                end
              end
              else if (poll_ff == POLL_LAST)
              begin
                sts_ff   <= `STS_TIMEOUT;
                state_ff <= S_LAG;
              end
              else
                poll_ff <= poll_ff + 8'h01;
            end
            STG_COEF:
              state_ff <= S_LAG;
            default:
            begin
              len_ff   <= len_ff - 8'h01;
              state_ff <= (len_ff == 8'h01) ? S_LAG : S_HOLD;
            end
          endcase
        end
        S_HOLD:
        begin
          // A full buffer parks the clock high between bytes.
          if (fifo_in_ready)
            state_ff <= S_LEAD;
        end
        S_LAG:
        begin
          if (tick)
          begin
            chip_select_n <= 1'b1;
            mosi          <= 1'b1;
            gap_ff        <= 2'h0;
            state_ff      <= S_GAP;
          end
        end
        S_GAP:
        begin
          if (tick)
          begin
            if (gap_ff == GAP_LAST)
            begin
              done        <= 1'b1;
              done_status <= sts_ff;
              state_ff    <= S_IDLE;
            end
            else
              gap_ff <= gap_ff + 2'h1;
          end
        end
        default:
          state_ff <= S_IDLE;
      endcase
    end
  end

endmodule

// File: rtl/sensor_host_map.vh
// Shared constants of the force sensor host controller.
`ifndef SENSOR_HOST_MAP_VH
`define SENSOR_HOST_MAP_VH

// ----------------------------------------------------------------------
// Request operations
// ----------------------------------------------------------------------
`define OP_RESET      3'h0
`define OP_SHUTDOWN   3'h1
`define OP_ACTIVE     3'h2
`define OP_IDLE       3'h3
`define OP_RESULT     3'h4
`define OP_WRITE_REG  3'h5
`define OP_COEF_READ  3'h6

// ----------------------------------------------------------------------
// Command codes and reply bytes
// ----------------------------------------------------------------------
`define CMD_WRITE_REG 8'hE0
`define CMD_COEF_READ 8'hD6
`define ACK_BYTE      8'h00
`define BUSY_BYTE     8'h00
`define READY_MARK    8'h01

// ----------------------------------------------------------------------
// Shadow sequencer states and completion status
// ----------------------------------------------------------------------
`define DEV_SHUTDOWN  2'h0
`define DEV_ACTIVE    2'h1
`define DEV_IDLE      2'h2
`define STS_OK        2'h0
`define STS_NEGATIVE_ACKNOWLEDGE      2'h1
`define STS_REFUSED   2'h2
`define STS_TIMEOUT   2'h3

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_NS        8
`define HALF_FAST_NS  100
`define HALF_SLOW_NS  500
`define HALF_FAST_CYC ((`HALF_FAST_NS + `CLK_NS - 1) / `CLK_NS)
`define HALF_SLOW_CYC ((`HALF_SLOW_NS + `CLK_NS - 1) / `CLK_NS)
`define BUSY_MAX_US   25
`define POLL_LIMIT    (((`BUSY_MAX_US * 1000) + (16 * `HALF_FAST_NS) - 1) / (16 * `HALF_FAST_NS) + 1)
`define GAP_TICKS     2

// ----------------------------------------------------------------------
// Receive buffer
// ----------------------------------------------------------------------
`define FIFO_WIDTH    8
`define FIFO_DEPTH    4

`endif

// File: rtl/sclk_tick_gen.v
// Half period enable pulse generator for the serial clock.
`timescale 1ns/10ps
module sclk_tick_gen
(
  input  wire       ref_clk,
  input  wire       sys_rst,
  input  wire       slow_sel,
  output reg        tick
);
`include "sensor_host_map.vh"

  localparam integer FAST_CYC  = `HALF_FAST_CYC;
  localparam integer SLOW_CYC  = `HALF_SLOW_CYC;
  localparam [5:0]   FAST_LAST = FAST_CYC[5:0] - 6'h01;
  localparam [5:0]   SLOW_LAST = SLOW_CYC[5:0] - 6'h01;

  reg  [5:0] cnt_ff;
  wire [5:0] last_w;

  // The slow rate serves interface supplies below two volts.
  assign last_w = slow_sel ? SLOW_LAST : FAST_LAST;

  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_ff <= 6'h00;
      tick   <= 1'b0;
    end
    else if (cnt_ff >= last_w)
    begin
      cnt_ff <= 6'h00;
      tick   <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 6'h01;
      tick   <= 1'b0;
    end
  end

endmodule

// File: rtl/rx_byte_fifo.v
// Small receive FIFO with registered read data.
`timescale 1ns/10ps
module rx_byte_fifo
#(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
)
(
  input  wire             ref_clk,
  input  wire             sys_rst,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  output reg              out_valid,
  output reg  [WIDTH-1:0] out_data,
  input  wire             out_ready
);

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr_ff;
  reg  [AW-1:0]    rd_ptr_ff;
  reg  [AW:0]      count_ff;
  wire             push_w;
  wire             pop_w;
  wire [AW-1:0]    nxt_rd_ptr;
  wire [AW:0]      nxt_count;

  assign in_ready   = (count_ff < DEPTH);
  assign push_w     = in_valid && in_ready;
  assign pop_w      = out_valid && out_ready;
  assign nxt_rd_ptr = pop_w ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
  assign nxt_count  = count_ff + {{AW{1'b0}}, push_w} - {{AW{1'b0}}, pop_w};

  always @(posedge ref_clk)
  begin
    if (push_w)
      mem[wr_ptr_ff] <= in_data;
  end

  // A word written into the slot about to be shown bypasses the array.
  always @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
      out_valid <= 1'b0;
      out_data  <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push_w)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
      out_valid <= (nxt_count != {(AW+1){1'b0}});
      out_data  <= (push_w && wr_ptr_ff == nxt_rd_ptr) ? in_data : mem[nxt_rd_ptr];
    end
  end

endmodule

// File: tb/sensor_spi_command_fsm_sva.sv
// Port level protocol checker for the sensor host controller.
`timescale 1ns/10ps
`include "sensor_host_map.vh"
module sensor_spi_command_fsm_chk
(
  input wire       ref_clk,
  input wire       sys_rst,
  input wire       slow_io,
  input wire       req_valid,
  input wire [2:0] req_op,
  input wire       req_ready,
  input wire       done,
  input wire [1:0] done_status,
  input wire [1:0] dev_state,
  input wire       sclk,
  input wire       mosi,
  input wire       chip_select_n,
  input wire       rx_valid,
  input wire [7:0] rx_data,
  input wire       rx_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  reg [6:0] low_cnt_ff;
  // Counts low samples of the serial clock so the half period can be judged.
  always @(posedge ref_clk or posedge sys_rst)
    if (sys_rst)
      low_cnt_ff <= 7'h0;
    else
      low_cnt_ff <= sclk ? 7'h0 : low_cnt_ff + 7'h1;
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_guard;
    req_op > 3'h6 || (dev_state == `DEV_ACTIVE && (req_op == `OP_IDLE || req_op == `OP_COEF_READ))
      || (dev_state == `DEV_IDLE && (req_op == `OP_RESULT || req_op == `OP_WRITE_REG));
  endsequence
  sequence s_refused;
    done && done_status == `STS_REFUSED && chip_select_n;
  endsequence
  property p_sclk_idle; chip_select_n |-> sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("clock low while deselected");
  property p_cs_toggle; $changed(chip_select_n) |-> sclk && $past(sclk); endproperty
  a_cs_toggle: assert property (p_cs_toggle) else $error("select moved with clock low");
  property p_mosi_edge; $changed(mosi) |-> $fell(sclk) || $rose(chip_select_n); endproperty
  a_mosi_edge: assert property (p_mosi_edge) else $error("data moved off falling edge");
  property p_low_time; $rose(sclk) |-> low_cnt_ff >= (slow_io ? 7'h3F : 7'h0D); endproperty
  a_low_time: assert property (p_low_time) else $error("clock low phase too short");
  // The first fall waits for two divider ticks, so the slow rate needs the wide bound.
  property p_lead; $fell(chip_select_n) |-> ##[1:130] $fell(sclk); endproperty
  a_lead: assert property (p_lead) else $error("no clock after select");
  property p_gap; $rose(chip_select_n) |-> chip_select_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("deselect gap too short");
  property p_refuse; s_take ##0 s_guard |=> s_refused; endproperty
  a_refuse: assert property (p_refuse) else $error("guarded request not refused");
  property p_done_pulse; done |=> !done && req_ready; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a single pulse");
  property p_take_drop; s_take |=> !req_ready; endproperty
  a_take_drop: assert property (p_take_drop) else $error("ready held after take");
  property p_state_frame; $changed(dev_state) |-> !chip_select_n; endproperty
  a_state_frame: assert property (p_state_frame) else $error("state moved outside frame");
  property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_data); endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("received byte dropped");
endmodule
bind sensor_spi_command_fsm sensor_spi_command_fsm_chk i_chk (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .slow_io(slow_io), .req_valid(req_valid), .req_op(req_op),
  .req_ready(req_ready), .done(done), .done_status(done_status), .dev_state(dev_state),
  .sclk(sclk), .mosi(mosi), .chip_select_n(chip_select_n), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_ready(rx_ready));

// File: tb/sensor_model.sv
// Behavioural force sensor answering the host over the serial link.
`timescale 1ns/10ps
`include "sensor_host_map.vh"
module sensor_model
#(
  parameter [7:0] CMD_RESET    = 8'h01,
  parameter [7:0] CMD_SHUTDOWN = 8'h02,
  parameter [7:0] CMD_ACTIVE   = 8'h03,
  parameter [7:0] CMD_IDLE     = 8'h04,
  parameter [7:0] CMD_RESULT   = 8'h05
)
(
  input  wire       sclk,
  input  wire       mosi,
  input  wire       chip_select_n,
  input  wire [7:0] busy_bytes,
  output reg        miso
);
  reg [1:0]  state_ff = `DEV_SHUTDOWN;
  reg [7:0]  cmd_ff = 8'h00;
  reg [7:0]  addr_ff = 8'h00;
  reg [7:0]  shift_ff = 8'h00;
  reg [10:0] nbit_ff = 11'h0;
  reg        ack;
  reg [7:0]  tx;
  wire [7:0] idx = nbit_ff[10:3];
  initial miso = 1'b1;
  always @*
  begin
    case (cmd_ff)
      CMD_RESET, CMD_SHUTDOWN, CMD_IDLE: ack = 1'b1;
      CMD_ACTIVE: ack = state_ff != `DEV_ACTIVE;
      CMD_RESULT, `CMD_WRITE_REG, `CMD_COEF_READ: ack = state_ff != `DEV_SHUTDOWN;
      default: ack = 1'b0;
    endcase
    if (idx == 8'h01)
      tx = ack ? `ACK_BYTE : 8'hFF;
    else if (idx < 8'h02 || !ack)
      tx = 8'hFF;
    else if (cmd_ff == CMD_RESULT)
      tx = 8'hA0 + idx;
    else if (cmd_ff == `CMD_WRITE_REG)
      tx = idx < 8'h04 + busy_bytes ? `BUSY_BYTE : `READY_MARK;
    else if (idx < 8'h03 + busy_bytes)
      tx = `BUSY_BYTE;
    else
      tx = idx == 8'h03 + busy_bytes ? `READY_MARK : addr_ff ^ 8'h5A;
  end
  always @(negedge chip_select_n) nbit_ff = 11'h0;
  always @(posedge sclk)
    if (!chip_select_n)
    begin
      shift_ff = {shift_ff[6:0], mosi};
      nbit_ff = nbit_ff + 11'h1;
      if (nbit_ff == 11'h8) cmd_ff = shift_ff;
      if (nbit_ff == 11'h18) addr_ff = shift_ff;
    end
  always @(negedge sclk)
    if (!chip_select_n) miso = tx[~nbit_ff[2:0]];
  // A released line would read as unknown, so the model shows the inverse of the last bit.
  always @(posedge chip_select_n)
  begin
    if (nbit_ff >= 11'h10 && ack)
      case (cmd_ff)
        CMD_RESET, CMD_SHUTDOWN: state_ff = `DEV_SHUTDOWN;
        CMD_ACTIVE: state_ff = `DEV_ACTIVE;
        CMD_IDLE: state_ff = `DEV_IDLE;
        default: state_ff = state_ff;
      endcase
    miso = ~miso;
  end
endmodule

// File: tb/sensor_spi_command_fsm_bench.sv
// Self-checking bench for the sensor host controller.
`timescale 1ns/10ps
`include "sensor_host_map.vh"
module sensor_spi_command_fsm_bench;
  reg        ref_clk, sys_rst, slow_io, req_valid, rx_ready;
  reg  [2:0] req_op;
  reg  [7:0] req_addr, req_data, req_len, busy_bytes;
  wire       req_ready, done, sclk, mosi, chip_select_n, miso, rx_valid;
  wire [1:0] done_status, dev_state;
  wire [7:0] rx_data;
  integer    miscompares, samples_checked, n, k;
  reg  [7:0] rxq[$];
  always #4 ref_clk = ~ref_clk;
  sensor_spi_command_fsm i_sensor_spi_command_fsm (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .slow_io(slow_io), .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr),
    .req_data(req_data), .req_len(req_len), .req_ready(req_ready), .done(done),
    .done_status(done_status), .dev_state(dev_state), .sclk(sclk), .mosi(mosi),
    .chip_select_n(chip_select_n), .miso(miso), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready));
  sensor_model i_sensor_model (.sclk(sclk), .mosi(mosi), .chip_select_n(chip_select_n),
    .busy_bytes(busy_bytes), .miso(miso));
  always @(posedge ref_clk)
    if (rx_valid && rx_ready) rxq.push_back(rx_data);
  task conclude;
  begin
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  task cmp(input string what, input [7:0] exp, input [7:0] got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  // Offers one request, waits for its completion and judges status and shadow state.
  task issue(input [2:0] op, input [7:0] addr, input [7:0] len, input [1:0] st, input [1:0] ds);
  begin
    n = 0;
    while (req_ready !== 1'b1 && n < 60000)
    begin
      @(posedge ref_clk);
      #1 n = n + 1;
    end
    req_op = op; req_addr = addr; req_data = ~addr; req_len = len; req_valid = 1'b1;
    @(posedge ref_clk);
    #1 req_valid = 1'b0;
    while (done !== 1'b1 && n < 60000)
    begin
      @(posedge ref_clk);
      #1 n = n + 1;
    end
    if (n >= 60000)
    begin
      miscompares = miscompares + 1;
      conclude;
    end
    cmp("status", {6'h0, st}, {6'h0, done_status});
    cmp("state", {6'h0, ds}, {6'h0, dev_state});
    cmp("sensor", {6'h0, i_sensor_model.state_ff}, {6'h0, dev_state});
  end
  endtask
  task t_boot;
  begin
    cmp("link idle", 8'h07, {5'h0, sclk, mosi, chip_select_n});
    issue(`OP_RESET, 8'h00, 8'h00, `STS_OK, `DEV_SHUTDOWN);
    $display("t_boot done");
  end
  endtask
  task t_ignored;
  begin
    for (k = 4; k < 7; k = k + 1)
      issue(k[2:0], 8'h10, 8'h02, `STS_NEGATIVE_ACKNOWLEDGE, `DEV_SHUTDOWN);
    issue(`OP_ACTIVE, 8'h00, 8'h00, `STS_OK, `DEV_ACTIVE);
    issue(`OP_ACTIVE, 8'h00, 8'h00, `STS_NEGATIVE_ACKNOWLEDGE, `DEV_ACTIVE);
    $display("t_ignored done");
  end
  endtask
  task t_result;
  begin
    rxq.delete();
    rx_ready = 1'b0;
    fork
      issue(`OP_RESULT, 8'h00, 8'h06, `STS_OK, `DEV_ACTIVE);
      begin
        repeat (2000) @(posedge ref_clk);
        #1 cmp("stall", 8'h03, {6'h0, sclk & ~chip_select_n, rx_valid});
        rx_ready = 1'b1;
      end
    join
    cmp("result count", 8'h06, rxq.size());
    for (k = 0; k < 6; k = k + 1)
      cmp("result byte", 8'hA2 + k, rxq[k]);
    issue(`OP_IDLE, 8'h00, 8'h00, `STS_REFUSED, `DEV_ACTIVE);
    issue(`OP_COEF_READ, 8'h00, 8'h00, `STS_REFUSED, `DEV_ACTIVE);
    busy_bytes = 8'h02;
    issue(`OP_WRITE_REG, 8'h21, 8'h00, `STS_OK, `DEV_ACTIVE);
    issue(3'h7, 8'h00, 8'h00, `STS_REFUSED, `DEV_ACTIVE);
    $display("t_result done");
  end
  endtask
  task t_idle;
  begin
    issue(`OP_SHUTDOWN, 8'h00, 8'h00, `STS_OK, `DEV_SHUTDOWN);
    issue(`OP_SHUTDOWN, 8'h00, 8'h00, `STS_OK, `DEV_SHUTDOWN);
    issue(`OP_IDLE, 8'h00, 8'h00, `STS_OK, `DEV_IDLE);
    issue(`OP_IDLE, 8'h00, 8'h00, `STS_OK, `DEV_IDLE);
    issue(`OP_RESULT, 8'h00, 8'h02, `STS_REFUSED, `DEV_IDLE);
    issue(`OP_WRITE_REG, 8'h00, 8'h00, `STS_REFUSED, `DEV_IDLE);
    rxq.delete();
    busy_bytes = 8'h03;
    issue(`OP_COEF_READ, 8'h3C, 8'h00, `STS_OK, `DEV_IDLE);
    busy_bytes = 8'h00;
    issue(`OP_COEF_READ, 8'h81, 8'h00, `STS_OK, `DEV_IDLE);
    cmp("coef count", 8'h02, rxq.size());
    cmp("coef byte", 8'h66, rxq[0]);
    cmp("coef byte", 8'hDB, rxq[1]);
    busy_bytes = 8'hC8;
    issue(`OP_COEF_READ, 8'h00, 8'h00, `STS_TIMEOUT, `DEV_IDLE);
    issue(`OP_ACTIVE, 8'h00, 8'h00, `STS_OK, `DEV_ACTIVE);
    $display("t_idle done");
  end
  endtask
  task t_slow;
  begin
    slow_io = 1'b1;
    issue(`OP_RESET, 8'h00, 8'h00, `STS_OK, `DEV_SHUTDOWN);
    slow_io = 1'b0;
    $display("t_slow done");
  end
  endtask
  initial
  begin
    ref_clk = 0; sys_rst = 1; slow_io = 0; req_valid = 0; rx_ready = 1; req_op = 0;
    req_addr = 0; req_data = 0; req_len = 0; busy_bytes = 0;
    miscompares = 0;
    samples_checked = 0;
    repeat (3) @(posedge ref_clk);
    #1 sys_rst = 0;
    t_boot;
    t_ignored;
    t_result;
    t_idle;
    t_slow;
    conclude;
  end
endmodule
